// ### design/rsc_pkg.sv
/*
 * constants for the reset and strap control block.
 * assumes one 40 MHz system clock and no register bus.
 */
package rsc_pkg;

	// ==========================================================
	// clock and release timing
	localparam int RSC_CLK_PERIOD_NS = 25;
	localparam int RSC_HOLD_W = 3;
	localparam int RSC_RELEASE_HOLD_CYCLES = 4;

	// ==========================================================
	// values after reset
	localparam logic RSC_ENDIAN_RESET = 1'b0;
	localparam logic [3:0] RSC_BOOT_RESET = 4'h0;
	localparam logic RSC_SEL_GENERAL_RESET = 1'b0;
	localparam logic RSC_SELECT_IDLE_N = 1'b1;

endpackage

// ### design/rsc_top.sv
/*
 * reset and strap control: merges reset sources, releases the internal
 * module reset synchronously, latches straps during reset and routes
 * the shared chip-select pins.
 * assumes pins arrive asynchronously; watchdog, chip-select and config
 * inputs come from logic on clk_sys.
 */
//
// Contract
// - master reset input resets all modules but this block and clock control; the code also clears this block's sel_general_2 and sel_general_3 on it.
// - reset output asserted while power-on, master reset or watchdog timeout is active.
// - power-on reset input is active high.
// - endian strap sampled in reset: high gives little endian, low big endian.
// - software picks sync memory select 0 or general select 2 for shared pin.
// - after reset sync memory select 1 drives its shared pin, not general select 3.
// - board holds boot mode pins during reset; block latches boot mode then.
`timescale 1ns/1ps
module rsc_top #(
	parameter int HOLD_CYCLES = rsc_pkg::RSC_RELEASE_HOLD_CYCLES
) (
	input wire logic clk_sys, // system clock, 40 MHz
	input wire logic resetn, // block reset, async, active low
	input wire logic por, // power-on reset pin, active high
	input wire logic master_reset_n, // master reset pin, active low
	input wire logic wdog_timeout, // watchdog timeout, clk_sys domain
	input wire logic endian_strap, // endian strap pin
	input wire logic [3:0] boot_mode_pins, // boot mode strap pins
	input wire logic cfg_wr, // config write strobe
	input wire logic cfg_sel_general_2, // 1 selects general select 2
	input wire logic cfg_sel_general_3, // 1 selects general select 3
	input wire logic sync_mem_select_0_n, // sync memory select 0
	input wire logic sync_mem_select_1_n, // sync memory select 1
	input wire logic general_select_2_n, // general select 2
	input wire logic general_select_3_n, // general select 3
	output logic reset_out_n, // reset output, active low
	output logic module_reset_n, // internal module reset, active low
	output logic little_endian, // latched endian strap
	output logic [3:0] boot_mode, // latched boot mode
	output logic shared_select_0_n, // shared pin of select 0 / 2
	output logic shared_select_1_n, // shared pin of select 1 / 3
	output logic sel_general_2, // current routing of shared pin 0
	output logic sel_general_3 // current routing of shared pin 1
);

	// elaboration check: the hold count must fit its counter
	if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << rsc_pkg::RSC_HOLD_W)) begin : gen_hold_check
		$error("HOLD_CYCLES out of range");
	end


	localparam logic [rsc_pkg::RSC_HOLD_W-1:0] HOLD = HOLD_CYCLES[rsc_pkg::RSC_HOLD_W-1:0];

	// ==========================================================
	// pin synchronisers
	logic por_meta, por_sync;
	logic mrst_meta_n, mrst_sync_n;
	logic endian_meta, endian_sync;
	logic [3:0] boot_meta, boot_sync;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			por_meta <= 1'b1;
			por_sync <= 1'b1;
			mrst_meta_n <= 1'b0;
			mrst_sync_n <= 1'b0;
		end else begin
			por_meta <= por;
			por_sync <= por_meta;
			mrst_meta_n <= master_reset_n;
			mrst_sync_n <= mrst_meta_n;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			endian_meta <= rsc_pkg::RSC_ENDIAN_RESET;
			endian_sync <= rsc_pkg::RSC_ENDIAN_RESET;
			boot_meta <= rsc_pkg::RSC_BOOT_RESET;
			boot_sync <= rsc_pkg::RSC_BOOT_RESET;
		end else begin
			endian_meta <= endian_strap;
			endian_sync <= endian_meta;
			boot_meta <= boot_mode_pins;
			boot_sync <= boot_meta;
		end
	end

	// ==========================================================
	// reset merge and synchronous release
	logic src_any;
	logic [rsc_pkg::RSC_HOLD_W-1:0] hold_cnt;
	logic release_ok;

	assign src_any = por_sync | ~mrst_sync_n | wdog_timeout;
	assign release_ok = (hold_cnt == HOLD) && !src_any;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hold_cnt <= '0;
		end else if (src_any) begin
			hold_cnt <= '0;
		end else if (hold_cnt != HOLD) begin
			hold_cnt <= hold_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reset_out_n <= 1'b0;
			module_reset_n <= 1'b0;
		end else begin
			reset_out_n <= release_ok;
			module_reset_n <= release_ok;
		end
	end

	reset_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		src_any |=> !reset_out_n)
		else $error("reset output not asserted by a source");
	por_level_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		por_sync |=> !module_reset_n ##0 !reset_out_n)
		else $error("power-on level did not reset");
	master_reset_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!mrst_sync_n |=> !module_reset_n)
		else $error("master reset did not reset modules");
	sync_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(module_reset_n) |-> $rose(reset_out_n) && !$past(src_any)
		&& $past(hold_cnt) == HOLD)
		else $error("module reset release not synchronous");
	outputs_pair_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		reset_out_n == module_reset_n)
		else $error("reset output and module reset differ");
	hold_restart_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		src_any |=> hold_cnt == '0)
		else $error("source did not restart release count");
	hold_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!src_any && hold_cnt != HOLD |=> hold_cnt == $past(hold_cnt) + 1'b1)
		else $error("release count did not advance");
	wdog_reset_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		wdog_timeout |=> !reset_out_n)
		else $error("watchdog timeout did not assert reset output");
	por_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		por |-> ##3 !reset_out_n)
		else $error("power-on pin high did not assert reset output");
	master_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!master_reset_n |-> ##3 !module_reset_n)
		else $error("master reset pin did not reset modules");

	// ==========================================================
	// strap capture while reset is active
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			little_endian <= rsc_pkg::RSC_ENDIAN_RESET;
			boot_mode <= rsc_pkg::RSC_BOOT_RESET;
		end else if (src_any) begin
			little_endian <= endian_sync;
			boot_mode <= boot_sync;
		end
	end

	endian_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		src_any |=> little_endian == $past(endian_sync))
		else $error("endian strap not captured in reset");
	endian_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!$past(src_any) |-> $stable(little_endian))
		else $error("endian changed outside reset");
	boot_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		src_any ##1 !src_any[*2] |-> boot_mode == $past(boot_sync, 2))
		else $error("boot mode not held from reset");
	boot_sample_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		src_any |=> boot_mode == $past(boot_sync))
		else $error("boot mode not sampled in reset");
	boot_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!$past(src_any) |-> $stable(boot_mode))
		else $error("boot mode changed outside reset");

	// ==========================================================
	// shared chip-select routing
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sel_general_2 <= rsc_pkg::RSC_SEL_GENERAL_RESET;
			sel_general_3 <= rsc_pkg::RSC_SEL_GENERAL_RESET;
		end else if (!module_reset_n) begin
			sel_general_2 <= rsc_pkg::RSC_SEL_GENERAL_RESET;
			sel_general_3 <= rsc_pkg::RSC_SEL_GENERAL_RESET;
		end else if (cfg_wr) begin
			sel_general_2 <= cfg_sel_general_2;
			sel_general_3 <= cfg_sel_general_3;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shared_select_0_n <= rsc_pkg::RSC_SELECT_IDLE_N;
			shared_select_1_n <= rsc_pkg::RSC_SELECT_IDLE_N;
		end else begin
			shared_select_0_n <= sel_general_2 ? general_select_2_n : sync_mem_select_0_n;
			shared_select_1_n <= sel_general_3 ? general_select_3_n : sync_mem_select_1_n;
		end
	end

	shared0_route_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		##1 shared_select_0_n == ($past(sel_general_2) ? $past(general_select_2_n)
		: $past(sync_mem_select_0_n)))
		else $error("shared pin 0 misrouted");
	default_sel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!module_reset_n ##1 !module_reset_n |-> !sel_general_3
		##1 shared_select_1_n == $past(sync_mem_select_1_n))
		else $error("select 1 not default after reset");
	shared1_route_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		##1 shared_select_1_n == ($past(sel_general_3) ? $past(general_select_3_n)
		: $past(sync_mem_select_1_n)))
		else $error("shared pin 1 misrouted");
	cfg_blocked_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!module_reset_n |=> !sel_general_2 && !sel_general_3)
		else $error("routing not forced to default in reset");
	cfg_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		module_reset_n && cfg_wr |=> sel_general_2 == $past(cfg_sel_general_2)
		&& sel_general_3 == $past(cfg_sel_general_3))
		else $error("routing write not taken");
	cfg_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		module_reset_n && !cfg_wr |=> $stable(sel_general_2) && $stable(sel_general_3))
		else $error("routing changed without a write");

endmodule

// ### bench/rsc_board.sv
/*
 * board reset circuit and strap pins.
 * assumes bench requests change at the falling clock edge; pins move
 * just after the rising edge, so no bench write races them.
 */
`timescale 1ns/1ps
module rsc_board (
	input wire logic clk_sys, // system clock
	input wire logic por_req, // hold power-on
	input wire logic mrst_req, // hold master reset
	input wire logic wiggle, // let straps toggle outside reset
	input wire logic reset_out_n, // device reset output
	input wire logic [4:0] straps, // endian and boot levels
	output logic por = 1'b1, // power-on pin
	output logic master_reset_n = 1'b1, // master reset pin
	output logic endian_strap = 1'b0, // endian pin
	output logic [3:0] boot_mode_pins = 4'h0 // boot pins
);
	logic [2:0] hold = 3'h0;
	// straps held in and after reset; toggled outside reset only on request
	always @(posedge clk_sys) begin
		por <= por_req;
		master_reset_n <= !mrst_req;
		hold <= (por_req || mrst_req || !reset_out_n) ? 3'h7 : hold - {2'h0, hold != 3'h0};
		if (wiggle && hold == 3'h0) begin
			{endian_strap, boot_mode_pins} <= ~{endian_strap, boot_mode_pins};
		end else begin
			{endian_strap, boot_mode_pins} <= straps;
		end
	end
endmodule

// ### bench/rsc_top_tb.sv
/*
 * self-checking bench for the reset and strap control block.
 * assumes rsc_board drives the pins; bench drives the rest.
 */
`timescale 1ns/1ps
module rsc_top_tb;
	localparam int HOLD = 3;
	logic clk_sys = 0, resetn = 0, wdog_timeout = 0, cfg_wr = 0, s2 = 0, s3 = 0;
	logic por_req = 1, mrst_req = 0, chk = 0, wiggle = 0;
	logic [3:0] cs = 4'hF;
	logic [4:0] straps;
	logic [31:0] seed = 32'h0000EA6E;
	logic [10:0] exp_q[$];
	logic [10:0] e;
	wire por, master_reset_n, endian_strap, reset_out_n, module_reset_n, little_endian;
	wire shared_select_0_n, shared_select_1_n, sel_general_2, sel_general_3;
	wire [3:0] boot_mode_pins, boot_mode;
	int error_cnt = 0, samples_checked = 0;
	rsc_board board (.clk_sys(clk_sys), .por_req(por_req), .mrst_req(mrst_req), .wiggle(wiggle),
		.reset_out_n(reset_out_n), .straps(straps), .por(por), .master_reset_n(master_reset_n),
		.endian_strap(endian_strap), .boot_mode_pins(boot_mode_pins));
	rsc_top #(.HOLD_CYCLES(HOLD)) dut (.clk_sys(clk_sys), .resetn(resetn), .por(por),
		.master_reset_n(master_reset_n), .wdog_timeout(wdog_timeout),
		.endian_strap(endian_strap), .boot_mode_pins(boot_mode_pins), .cfg_wr(cfg_wr),
		.cfg_sel_general_2(s2), .cfg_sel_general_3(s3), .sync_mem_select_0_n(cs[0]),
		.sync_mem_select_1_n(cs[1]), .general_select_2_n(cs[2]), .general_select_3_n(cs[3]),
		.reset_out_n(reset_out_n), .module_reset_n(module_reset_n),
		.little_endian(little_endian), .boot_mode(boot_mode),
		.shared_select_0_n(shared_select_0_n), .shared_select_1_n(shared_select_1_n),
		.sel_general_2(sel_general_2), .sel_general_3(sel_general_3));
	// ==========================================================
	// helpers
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [10:0] ev(logic r, logic [1:0] g);
		return {r, r, straps, g, g[1] ? cs[2] : cs[0], g[0] ? cs[3] : cs[1]};
	endfunction
	task automatic check(string n, logic [3:0] s, logic [3:0] x);
		samples_checked++;
		if (s !== x) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask
	task finish_test;
		if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task note(logic [10:0] x);
		exp_q.push_back(x);
		chk = 1;
		@(negedge clk_sys);
		chk = 0;
	endtask
	task cyc(int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task rel;
		int i;
		for (i = 0; i < 40 && reset_out_n !== 1'b1; i++) @(negedge clk_sys);
		if (i == 40) begin
			check("release", 4'h0, 4'h1);
			finish_test;
		end
	endtask
	// ==========================================================
	// clock, stimulus and monitor
	initial forever #12.5 clk_sys = ~clk_sys;
	initial forever begin
		@(posedge clk_sys);
		if (chk) begin
			#1 e = exp_q.pop_front();
			check("reset_out_n", {3'h0, reset_out_n}, {3'h0, e[10]});
			check("module_reset_n", {3'h0, module_reset_n}, {3'h0, e[9]});
			check("little_endian", {3'h0, little_endian}, {3'h0, e[8]});
			check("boot_mode", boot_mode, e[7:4]);
			check("sel_general", {2'h0, sel_general_2, sel_general_3}, {2'h0, e[3:2]});
			check("shared", {2'h0, shared_select_0_n, shared_select_1_n}, {2'h0, e[1:0]});
		end
	end
	initial begin
		straps = 5'(xs());
		cyc(2);
		resetn = 1;
		{cfg_wr, s2, s3} = 3'h7;
		cyc(1);
		cfg_wr = 0;
		cyc(5);
		note(ev(0, 2'h0));
		por_req = 0;
		// board edge, two sync stages, then the hold count: last edge still in reset
		cyc(HOLD + 2);
		note(ev(0, 2'h0));
		rel;
		note(ev(1, 2'h0));
		wiggle = 1;
		for (int k = 0; k < 4; k++) begin
			cs = 4'(xs());
			{s2, s3} = 2'(k);
			cfg_wr = 1;
			cyc(1);
			cfg_wr = 0;
			cyc(2);
			note(ev(1, 2'(k)));
		end
		wiggle = 0;
		cs = 4'hF;
		// straps back on the pins and through the synchroniser first
		cyc(2);
		wdog_timeout = 1;
		cyc(1);
		wdog_timeout = 0;
		cyc(1);
		note(ev(0, 2'h0));
		rel;
		note(ev(1, 2'h0));
		straps = {~straps[4], 4'(xs())};
		mrst_req = 1;
		cyc(6);
		note(ev(0, 2'h0));
		mrst_req = 0;
		rel;
		note(ev(1, 2'h0));
		cyc(2);
		finish_test;
	end
endmodule
